// >>> verilog/program_sequencer_stack.sv
// Program sequencer: four-phase instruction cycle, prefetch pipeline,
// program counter, hidden return stack and interrupt entry.
// Assumes program memory answers combinationally on pmem_addr and
// that int_req is already qualified by the interrupt enables.
`timescale 1ns/100ps
`default_nettype none
module program_sequencer_stack
    import seq_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            small_variant,
    input  wire logic [7:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [7:0]           reg_rdata,
    output logic [PC_W-1:0]      pmem_addr,
    input  wire logic [15:0]     prog_data,
    output logic                 fetch_strobe,
    output logic [3:0]           instruction_cycle_phases,
    input  wire logic            int_req,
    output logic                 int_ack,
    output logic                 stack_full
);
    phase_t          phase_reg;
    phase_t          phase_next;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;
    instr_t          ir_reg;
    logic [7:0]      acc_reg;
    flags_t          flags_reg;
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_reg;
    logic [3:0]      depth_reg;
    logic            int_pend_reg;
    logic            low_pend_reg;
    logic [7:0]      low_data_reg;
    logic [7:0]      rdata_reg;
    logic            int_ack_reg;

    // =========================================================
    // Decode of the instruction being executed
    logic            at_t4;
    logic            is_alu;
    logic            is_skz;
    logic            is_jmp;
    logic            is_call;
    logic            is_return;
    logic            is_pclw;
    logic            skip_taken;
    logic            instr_redirect;
    logic            low_apply;
    logic            int_take;
    logic            redirect;
    logic            push;
    logic            pop;
    logic [SP_W-1:0] sp_dec;
    logic [PC_W-1:0] stack_top;
    logic [PC_W-1:0] pc_mask;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] pc_target;
    logic [PC_W-1:0] branch_addr;
    logic [7:0]      alu_result;
    flags_t          alu_flags;

    assign at_t4       = (phase_reg == PH_T4);
    assign is_alu      = (ir_reg.cls == CLS_ALU);
    assign is_skz      = (ir_reg.cls == CLS_SKZ);
    assign is_jmp      = (ir_reg.cls == CLS_JMP);
    assign is_call     = (ir_reg.cls == CLS_CALL);
    assign is_return   = (ir_reg.cls == CLS_RETURN) || (ir_reg.cls == CLS_INT_RETURN);
    assign is_pclw     = (ir_reg.cls == CLS_PCLW);
    assign branch_addr = {ir_reg.op, ir_reg.imm};
    assign skip_taken  = is_skz && alu_flags.z;

    assign instr_redirect = is_jmp || is_call || is_return || is_pclw || skip_taken;
    // A software write to the low byte waits for a cycle whose own
    // instruction does not branch, so no branch is ever lost.
    assign low_apply = low_pend_reg && !instr_redirect;
    // Interrupt entry is held off while the stack is full, and while any
    // other redirect is being taken, so the pushed address stays exact.
    assign int_take  = int_pend_reg && !stack_full && !instr_redirect && !low_pend_reg;
    assign redirect  = instr_redirect || low_apply || int_take;
    assign push      = at_t4 && (is_call || int_take);
    assign pop       = at_t4 && is_return;

    assign stack_full = (depth_reg == DEPTH_FULL);
    assign sp_dec     = SP_W'(sp_reg - 3'h1);
    assign stack_top  = stack_mem[sp_dec];

    // =========================================================
    // Program counter next value
    assign pc_mask = small_variant ? PC_MASK_SMALL : PC_MASK_LARGE;
    assign pc_inc  = PC_W'(pc_reg + PC_ONE);

    assign pc_target = (is_jmp || is_call) ? branch_addr :
                       is_return           ? stack_top :
                       is_pclw             ? {pc_reg[PC_W-1:8], acc_reg} :
                       skip_taken          ? pc_inc :
                       low_apply           ? {pc_reg[PC_W-1:8], low_data_reg} :
                                             INT_VECTOR;

    assign pc_next = (redirect ? pc_target : pc_inc) & pc_mask;

    // =========================================================
    // Phase sequencer
    always_comb begin
        case (phase_reg)
            PH_T1:   phase_next = PH_T2;
            PH_T2:   phase_next = PH_T3;
            PH_T3:   phase_next = PH_T4;
            default: phase_next = PH_T1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= PH_T1;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // The counter moves on the edge that opens phase one, and the word
    // fetched from it during this cycle is captured on that same edge.
    // A redirect replaces the capture with a dummy, which costs one cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_reg <= PC_RESET;
            ir_reg <= INSTR_DUMMY;
        end else if (at_t4) begin
            pc_reg <= pc_next;
            ir_reg <= redirect ? INSTR_DUMMY : instr_t'(prog_data);
        end
    end

    // =========================================================
    // ALU and accumulator
    alu8 u_alu (
        .op        (alu_op_t'(ir_reg.op)),
        .a         (acc_reg),
        .b         (ir_reg.imm),
        .flags_in  (flags_reg),
        .result    (alu_result),
        .flags_out (alu_flags)
    );

    logic acc_bus_wr;
    logic low_bus_wr;

    assign acc_bus_wr = reg_wr && (reg_addr == ADDR_ACC);
    assign low_bus_wr = reg_wr && (reg_addr == ADDR_PC_LOW);

    // A bus write to the accumulator wins over an ALU result in the same
    // cycle; the skip compare never touches the accumulator or flags.
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_reg   <= ACC_RESET;
            flags_reg <= FLAGS_RESET;
        end else if (acc_bus_wr) begin
            acc_reg <= reg_wdata;
        end else if (at_t4 && is_alu) begin
            acc_reg   <= alu_result;
            flags_reg <= alu_flags;
        end
    end

    // =========================================================
    // Return stack, one entry per generate slot
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
        always_ff @(posedge clk) begin
            if (push && (sp_reg == SP_W'(i))) begin
                stack_mem[i] <= pc_reg;
            end
        end
    end

    // The pointer wraps, so a push on a full stack lands on the oldest
    // entry and the depth stays at its ceiling.
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_reg    <= '0;
            depth_reg <= 4'h0;
        end else if (push) begin
            sp_reg    <= SP_W'(sp_reg + 3'h1);
            depth_reg <= stack_full ? depth_reg : 4'(depth_reg + 4'h1);
        end else if (pop) begin
            sp_reg    <= sp_dec;
            depth_reg <= (depth_reg == 4'h0) ? depth_reg : 4'(depth_reg - 4'h1);
        end
    end

    // =========================================================
    // Interrupt and low-byte write pending flags; a new event wins
    // over the clear that happens in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            int_pend_reg <= 1'b0;
            int_ack_reg  <= 1'b0;
            low_pend_reg <= 1'b0;
            low_data_reg <= 8'h00;
        end else begin
            int_pend_reg <= int_req || (int_pend_reg && !(at_t4 && int_take));
            int_ack_reg  <= at_t4 && int_take;
            low_pend_reg <= low_bus_wr || (low_pend_reg && !(at_t4 && low_apply));
            if (low_bus_wr) begin
                low_data_reg <= reg_wdata;
            end
        end
    end

    // =========================================================
    // Register read port; the stack is deliberately absent.
    logic [7:0] rd_mux;

    assign rd_mux = (reg_addr == ADDR_ACC)    ? acc_reg :
                    (reg_addr == ADDR_PC_LOW) ? pc_reg[7:0] :
                    (reg_addr == ADDR_STATUS) ? {4'h0, flags_reg} :
                                                8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata                = rdata_reg;
    assign pmem_addr                = pc_reg;
    assign fetch_strobe             = phase_reg[0];
    assign instruction_cycle_phases = phase_reg;
    assign int_ack                  = int_ack_reg;

    // =========================================================
    // Assertions
    sequence s_phase_walk;
        phase_reg == PH_T2 ##1 phase_reg == PH_T3 ##1 phase_reg == PH_T4 ##1 phase_reg == PH_T1;
    endsequence

    property p_phase_cycle;
        @(posedge clk) disable iff (rst)
        phase_reg == PH_T1 |=> s_phase_walk;
    endproperty
    a_phase_cycle: assert property (p_phase_cycle) else $error("phase order broken");

    property p_pc_moves_at_t1;
        @(posedge clk) disable iff (rst)
        $changed(pc_reg) |-> phase_reg == PH_T1;
    endproperty
    a_pc_moves_at_t1: assert property (p_pc_moves_at_t1) else $error("pc moved off phase one");

    property p_pc_increment;
        @(posedge clk) disable iff (rst)
        at_t4 && !redirect |=> pc_reg == (PC_W'($past(pc_reg) + PC_ONE) & $past(pc_mask));
    endproperty
    a_pc_increment: assert property (p_pc_increment) else $error("pc did not increment");

    sequence s_dummy_cycle;
        (ir_reg == INSTR_DUMMY)[*4];
    endsequence

    property p_branch_two_cycles;
        @(posedge clk) disable iff (rst)
        at_t4 && (is_jmp || is_call) |=> pc_reg == $past(branch_addr & pc_mask) ##0 s_dummy_cycle;
    endproperty
    a_branch_two_cycles: assert property (p_branch_two_cycles) else $error("branch timing wrong");

    property p_skip_dummy;
        @(posedge clk) disable iff (rst)
        at_t4 && skip_taken |=> s_dummy_cycle;
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) else $error("skip kept prefetch");

    property p_low_page;
        @(posedge clk) disable iff (rst)
        at_t4 && low_apply |=> pc_reg[PC_W-1:8] == $past(pc_reg[PC_W-1:8])
                               && pc_reg[7:0] == $past(low_data_reg) && ir_reg == INSTR_DUMMY;
    endproperty
    a_low_page: assert property (p_low_page) else $error("low byte jump left page");

    property p_reset_state;
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> pc_reg == PC_RESET && depth_reg == 4'h0 && phase_reg == PH_T1;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_int_deferred;
        @(posedge clk) disable iff (rst)
        int_pend_reg && stack_full && !pop |=> !int_ack_reg && int_pend_reg;
    endproperty
    a_int_deferred: assert property (p_int_deferred) else $error("interrupt taken on full stack");

    property p_call_overflow;
        @(posedge clk) disable iff (rst)
        at_t4 && is_call && stack_full |=> stack_full && sp_reg == SP_W'($past(sp_reg) + 3'h1);
    endproperty
    a_call_overflow: assert property (p_call_overflow) else $error("overflow push wrong");

    property p_return_restore;
        @(posedge clk) disable iff (rst)
        at_t4 && is_return |=> pc_reg == ($past(stack_top) & $past(pc_mask));
    endproperty
    a_return_restore: assert property (p_return_restore) else $error("return address wrong");

endmodule
`default_nettype wire

// >>> verilog/seq_pkg.sv
// Constants, types and encodings shared by the program sequencer and its ALU.
// Assumes a single 200 MHz clock and a synchronous, active-high reset.
package seq_pkg;

    localparam int PC_W        = 12;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W        = 3;

    localparam logic [PC_W-1:0] PC_RESET      = 12'h000;
    localparam logic [PC_W-1:0] INT_VECTOR    = 12'h004;
    localparam logic [PC_W-1:0] PC_ONE        = 12'h001;
    localparam logic [PC_W-1:0] PC_MASK_SMALL = 12'h7FF;
    localparam logic [PC_W-1:0] PC_MASK_LARGE = 12'hFFF;
    localparam logic [3:0]      DEPTH_FULL    = 4'h8;

    // =========================================================
    // Register map
    localparam logic [7:0] ADDR_ACC    = 8'h00;
    localparam logic [7:0] ADDR_PC_LOW = 8'h02;
    localparam logic [7:0] ADDR_STATUS = 8'h03;
    localparam logic [7:0] ACC_RESET   = 8'h00;

    // =========================================================
    // Instruction classes
    localparam logic [3:0] CLS_NOP        = 4'h0;
    localparam logic [3:0] CLS_ALU        = 4'h1;
    localparam logic [3:0] CLS_SKZ        = 4'h2;
    localparam logic [3:0] CLS_JMP        = 4'h3;
    localparam logic [3:0] CLS_CALL       = 4'h4;
    localparam logic [3:0] CLS_RETURN     = 4'h5;
    localparam logic [3:0] CLS_INT_RETURN = 4'h6;
    localparam logic [3:0] CLS_PCLW       = 4'h7;

    typedef enum logic [3:0] {
        OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3,
        OP_DAA = 4'h4, OP_AND = 4'h5, OP_OR  = 4'h6, OP_XOR = 4'h7,
        OP_CPL = 4'h8, OP_RR  = 4'h9, OP_RRC = 4'hA, OP_RL  = 4'hB,
        OP_RLC = 4'hC, OP_INC = 4'hD, OP_DEC = 4'hE, OP_MOV = 4'hF
    } alu_op_t;

    typedef enum logic [3:0] {
        PH_T1 = 4'h1,
        PH_T2 = 4'h2,
        PH_T3 = 4'h4,
        PH_T4 = 4'h8
    } phase_t;

    typedef struct packed {
        logic [3:0] cls;
        logic [3:0] op;
        logic [7:0] imm;
    } instr_t;

    // Status byte layout: bits 7..4 read zero, then ov, z, ac, c.
    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_t;

    localparam instr_t INSTR_DUMMY = 16'h0000;
    localparam flags_t FLAGS_RESET = 4'h0;

endpackage

// >>> verilog/alu8.sv
// Eight-bit ALU of the sequencer core, purely combinational.
// Assumes the caller keeps flags that an operation leaves untouched.
`timescale 1ns/100ps
`default_nettype none
module alu8
    import seq_pkg::*;
(
    input  wire alu_op_t    op,
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire flags_t     flags_in,
    output logic [7:0]      result,
    output flags_t          flags_out
);
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] addend;
    logic       cin;
    logic [8:0] daa_val;

    // =========================================================
    // Adder shared by add, subtract and their carry forms
    // Subtract adds the complement, so carry set means no borrow.
    assign addend   = ((op == OP_SUB) || (op == OP_SBC)) ? ~b : b;
    assign cin      = (op == OP_SUB) ? 1'b1 : ((op == OP_ADC) || (op == OP_SBC)) ? flags_in.c : 1'b0;
    assign sum      = {1'b0, a} + {1'b0, addend} + {8'h00, cin};
    assign low      = {1'b0, a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    assign daa_val  = {1'b0, a}
                    + (((a[3:0] > 4'h9) || flags_in.ac) ? 9'h006 : 9'h000)
                    + (((a[7:4] > 4'h9) || flags_in.c) ? 9'h060 : 9'h000);

    always_comb begin
        flags_out = flags_in;
        result    = 8'h00;
        case (op)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
                result       = sum[7:0];
                flags_out.c  = sum[8];
                flags_out.ac = low[4];
                flags_out.ov = (a[7] == addend[7]) && (sum[7] != a[7]);
            end
            OP_DAA: begin
                result      = daa_val[7:0];
                flags_out.c = daa_val[8] | flags_in.c;
            end
            OP_AND:  result = a & b;
            OP_OR:   result = a | b;
            OP_XOR:  result = a ^ b;
            OP_CPL:  result = ~a;
            OP_RR:   result = {a[0], a[7:1]};
            OP_RRC: begin
                result      = {flags_in.c, a[7:1]};
                flags_out.c = a[0];
            end
            OP_RL:   result = {a[6:0], a[7]};
            OP_RLC: begin
                result      = {a[6:0], flags_in.c};
                flags_out.c = a[7];
            end
            OP_INC:  result = 8'(a + 8'h01);
            OP_DEC:  result = 8'(a - 8'h01);
            default: result = b;
        endcase
        // Zero follows every operation, rotates included.
        flags_out.z = (result == 8'h00);
    end

endmodule
`default_nettype wire

// >>> tb/prog_mem_model.sv
// Program memory and interrupt source standing at the sequencer's far side.
// Assumes the bench fills the array while reset is held, and pulses irq_raise.
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model
    import seq_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic [PC_W-1:0] pmem_addr,
    output logic [15:0]          prog_data,
    input  wire logic            irq_raise,
    input  wire logic            int_ack,
    output logic                 int_req
);
    // ==========
    // Storage
    logic [15:0] mem [0:4095];

    // The word follows the address at once, because the core samples it in T4.
    assign prog_data = mem[pmem_addr];

    // ==========
    // Interrupt source
    // The request is a one-cycle event, so the core alone must keep a
    // deferred one. A held level would be latched again after entry.
    // Acknowledges are counted so each request is seen serviced once.
    int ack_count;

    always_ff @(posedge clk) begin
        if (rst) begin
            int_req   <= 1'b0;
            ack_count <= 0;
        end else begin
            int_req <= irq_raise;
            if (int_ack) begin
                ack_count <= ack_count + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the program sequencer with its return stack.
// Assumes a 200 MHz clock and programs loaded into the memory model.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import seq_pkg::*;
    logic            clk;
    logic            rst;
    logic            small_variant;
    logic            reg_wr;
    logic            reg_rd;
    logic            irq_raise;
    logic [7:0]      reg_addr;
    logic [7:0]      reg_wdata;
    logic [7:0]      reg_rdata;
    logic [PC_W-1:0] pmem_addr;
    logic [15:0]     prog_data;
    logic            fetch_strobe;
    logic            int_req;
    logic            int_ack;
    logic            stack_full;
    logic [3:0]      instruction_cycle_phases;
    int              n_mismatch;
    int              comparisons;
    // Fields: op, first operand, immediate, result, status mask, status.
    logic [43:0]     alu_tbl [17] = '{
        44'h0_12_34_46_05_00, 44'h1_12_34_46_05_00, 44'h2_34_12_22_05_01,
        44'h3_34_12_21_05_01, 44'h4_0A_00_10_04_00, 44'h5_F0_3C_30_05_00,
        44'h6_F0_0F_FF_05_00, 44'h7_FF_FF_00_05_04, 44'h8_0F_00_F0_05_00,
        44'h9_01_00_80_05_00, 44'hA_01_00_00_05_05, 44'hB_80_00_01_05_00,
        44'hC_80_00_00_05_05, 44'hD_FF_00_00_04_04, 44'hE_01_00_00_04_04,
        44'hF_11_5A_5A_04_00, 44'h0_80_80_00_0F_0D};

    program_sequencer_stack uut (.clk(clk), .rst(rst), .small_variant(small_variant),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pmem_addr(pmem_addr), .prog_data(prog_data),
        .fetch_strobe(fetch_strobe), .instruction_cycle_phases(instruction_cycle_phases),
        .int_req(int_req), .int_ack(int_ack), .stack_full(stack_full));
    prog_mem_model pm (.clk(clk), .rst(rst), .pmem_addr(pmem_addr), .prog_data(prog_data),
        .irq_raise(irq_raise), .int_ack(int_ack), .int_req(int_req));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic prep(input logic sv);
        @(posedge clk);
        rst <= 1'b1;
        small_variant <= sv;
        for (int i = 0; i < 4096; i++) begin
            pm.mem[i] = 16'h0000;
        end
    endtask

    task automatic go;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic put(input logic [11:0] a, input logic [3:0] c, input logic [11:0] v);
        pm.mem[a] = {c, v};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // The pc snapshot is taken in the strobe cycle, the one the read reports.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [11:0] p);
        reg_addr <= a;
        reg_rd <= 1'b1;
        #1 p = pmem_addr;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask

    task automatic chk_acc(input logic [7:0] e);
        logic [7:0]  d;
        logic [11:0] p;
        rd(ADDR_ACC, d, p);
        chk(16'(d), 16'(e), "accumulator");
    endtask

    task automatic trace(input logic [11:0] e[$]);
        foreach (e[i]) begin
            #1 chk(16'(pmem_addr), 16'(e[i]), "fetch address");
            repeat (4) @(posedge clk);
        end
    endtask

    // ==========
    // Scenarios
    task automatic t_phase;
        logic [3:0] ph;
        prep(1'b0);
        go();
        for (int k = 0; k < 12; k++) begin
            ph = 4'(1 << (k % 4));
            #1 chk(16'(instruction_cycle_phases), 16'(ph), "phase");
            chk(16'(fetch_strobe), 16'(ph[0]), "fetch strobe");
            chk(16'(pmem_addr), 16'(k / 4), "fetch address");
            chk(16'({stack_full, int_ack}), 16'h0000, "idle flags");
            @(posedge clk);
        end
    endtask

    task automatic t_alu;
        logic [43:0] t;
        logic [7:0]  d;
        logic [11:0] p;
        for (int i = 0; i < 17; i++) begin
            t = alu_tbl[i];
            prep(1'b0);
            put(12'h000, CLS_ALU, {OP_MOV, t[39:32]});
            put(12'h001, CLS_ALU, {t[43:40], t[31:24]});
            put(12'h002, CLS_JMP, 12'h002);
            go();
            repeat (24) @(posedge clk);
            chk_acc(t[23:16]);
            rd(ADDR_STATUS, d, p);
            chk(16'(d & t[15:8]), 16'(t[7:0]), "status");
        end
    endtask

    task automatic t_jump;
        prep(1'b0);
        put(12'h001, CLS_JMP, 12'h100);
        put(12'h002, CLS_ALU, 12'hFEE);
        put(12'h100, CLS_ALU, 12'h001);
        put(12'h101, CLS_JMP, 12'h101);
        go();
        trace('{12'h000, 12'h001, 12'h002, 12'h100, 12'h101, 12'h102});
        chk_acc(8'h01);
    endtask

    task automatic t_call;
        prep(1'b0);
        put(12'h000, CLS_CALL, 12'h010);
        put(12'h001, CLS_ALU, 12'hF11);
        put(12'h002, CLS_JMP, 12'h002);
        put(12'h010, CLS_ALU, 12'hF22);
        put(12'h011, CLS_RETURN, 12'h000);
        go();
        trace('{12'h000, 12'h001, 12'h010, 12'h011, 12'h012, 12'h001, 12'h002});
        chk_acc(8'h11);
    endtask

    task automatic t_skip;
        prep(1'b0);
        put(12'h000, CLS_ALU, 12'hF01);
        put(12'h001, CLS_SKZ, 12'h500);
        put(12'h002, CLS_ALU, 12'hFEE);
        put(12'h003, CLS_SKZ, 12'h5FF);
        put(12'h004, CLS_ALU, 12'h010);
        put(12'h005, CLS_JMP, 12'h005);
        go();
        repeat (40) @(posedge clk);
        chk_acc(8'h11);
    endtask

    task automatic t_low_byte;
        logic [7:0]  d;
        logic [11:0] p;
        prep(1'b0);
        put(12'h000, CLS_JMP, 12'h305);
        put(12'h305, CLS_JMP, 12'h305);
        put(12'h040, CLS_ALU, 12'hFEE);
        put(12'h340, CLS_ALU, 12'h05A);
        put(12'h341, CLS_JMP, 12'h341);
        go();
        repeat (20) @(posedge clk);
        rd(ADDR_PC_LOW, d, p);
        chk(16'(p), 16'h0306, "pc in read cycle");
        chk(16'(d), 16'h0006, "pc low byte");
        rd(8'h7F, d, p);
        chk(16'(d), 16'h0000, "unmapped read");
        wr(ADDR_PC_LOW, 8'h40);
        repeat (24) @(posedge clk);
        chk_acc(8'h5A);
        #1 chk(16'(pmem_addr[11:8]), 16'h0003, "page kept");
    endtask

    task automatic t_small;
        prep(1'b1);
        put(12'h000, CLS_JMP, 12'h8A0);
        put(12'h0A0, CLS_ALU, 12'h077);
        put(12'h0A1, CLS_PCLW, 12'h000);
        put(12'h0A2, CLS_ALU, 12'hFEE);
        put(12'h077, CLS_JMP, 12'h877);
        put(12'h8A0, CLS_ALU, 12'hFEE);
        go();
        repeat (40) @(posedge clk);
        chk_acc(8'h77);
        wr(ADDR_ACC, 8'hC3);
        chk_acc(8'hC3);
        #1 chk(16'(pmem_addr[11:4]), 16'h0007, "narrow pc");
    endtask

    // Nine nested calls overflow the stack; the deferred interrupt runs in between.
    task automatic t_stack;
        int n;
        prep(1'b0);
        for (int i = 0; i < 9; i++) begin
            put(12'(i * 16), CLS_CALL, 12'(i * 16 + 16));
            put(12'(i * 16 + 17), CLS_RETURN, 12'h000);
        end
        put(12'h011, CLS_JMP, 12'h011);
        put(INT_VECTOR, CLS_INT_RETURN, 12'h000);
        go();
        for (n = 0; n < 400 && pmem_addr !== 12'h090; n++) begin
            @(posedge clk);
            #1;
        end
        chk(16'(pmem_addr), 16'h0090, "deepest call");
        chk(16'(stack_full), 16'h0001, "stack full");
        @(posedge clk);
        irq_raise <= 1'b1;
        @(posedge clk);
        irq_raise <= 1'b0;
        for (n = 0; n < 100; n++) begin
            #1;
            if (stack_full !== 1'b1) break;
            chk(16'(int_ack), 16'h0000, "ack while full");
            @(posedge clk);
        end
        for (n = 0; n < 40 && int_ack !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(16'(int_ack), 16'h0001, "ack after return");
        chk(16'(pmem_addr), 16'(INT_VECTOR), "vector");
        repeat (300) @(posedge clk);
        #1 chk(16'({stack_full, pmem_addr[11:4]}), 16'h0001, "oldest lost");
        chk(16'(pm.ack_count), 16'h0001, "single entry");
    endtask

    // ==========
    // Run control
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The whole run needs about 1300 cycles; the limit leaves ample margin.
    initial begin
        #100000;
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end

    initial begin
        rst = 1'b1;
        small_variant = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        irq_raise = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        n_mismatch = 0;
        comparisons = 0;
        t_phase();
        t_alu();
        t_jump();
        t_call();
        t_skip();
        t_low_byte();
        t_small();
        t_stack();
        results();
    end
endmodule
`default_nettype wire
